// ---- sss_regs.svh ----
// Timing counts and codes of the soft-start sequencer
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH

// Oscillator cycles per phase
`define SSS_SETTLE_CYC  12'h400
`define SSS_DISCH_CYC   12'h018
`define SSS_RAMP_CYC    12'h800
// Feedback offset code at full scale and at zero
`define SSS_OFFSET_FULL 12'h800
`define SSS_OFFSET_ZERO 12'h000
// System clocks per oscillator cycle (10 MHz / 300 kHz, rounded down)
`define SSS_OSC_DIV     6'h21

`endif

// ---- sss_pkg.sv ----
// Types shared by the soft-start sequencer
package sss_pkg;

  // ****************************************
  // Sequencer states, Gray coded
  // ****************************************
  typedef enum logic [2:0] {
    SSS_RESET  = 3'h0,
    SSS_SETTLE = 3'h1,
    SSS_DISCH  = 3'h3,
    SSS_RAMP   = 3'h2,
    SSS_RUN    = 3'h6
  } sss_state_t;

  // ****************************************
  // Gate drive pair
  // ****************************************
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } sss_gate_t;

  // ****************************************
  // Analog comparator results from the pins
  // ****************************************
  typedef struct packed {
    logic supply_ok;
    logic node_high;
    logic pwm_cmp;
  } sss_sense_t;

endpackage : sss_pkg

// ---- sss_sync.sv ----
// Two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/10ps
module sss_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        next_stage1[gi] = i_async[gi];
        next_stage2[gi] = stage1[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign o_sync = stage2;

endmodule : sss_sync

// ---- sss_sequencer.sv ----
// Reset and soft-start sequencer of a synchronous buck controller
// Operation
// - Power-on detect starts sequence without command
// - In reset both gates low until released
// - Internal sink keeps shutdown node low
// - Wait 1024 oscillator cycles after reset
// - Force node to 0.8V for 24 cycles
// - Feedback offset ramps 0.8V to 0V, 2048 cycles
// - Node low or supply low re-enters reset
// - Disabled: oscillator stops, gates low, re-arm
`timescale 1ns/10ps
`include "sss_regs.svh"
module sss_sequencer #(
  parameter logic [5:0] OSC_DIV = `SSS_OSC_DIV
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  input  wire sss_pkg::sss_sense_t i_sense,
  output sss_pkg::sss_gate_t      o_gate,
  output logic                    o_sink_enable,
  output logic                    o_node_force,
  output logic [11:0]             o_offset,
  output logic                    o_osc_enable,
  output sss_pkg::sss_state_t     o_state
);
  import sss_pkg::*;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [2:0] sense_s;
  logic       supply_s;
  logic       node_s;
  logic       pwm_s;
  logic       release_ok;

  sss_sync #(.WIDTH(3)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_sense),
    .o_sync    (sense_s)
  );

  assign supply_s   = sense_s[2];
  assign node_s     = sense_s[1];
  assign pwm_s      = sense_s[0];
  assign release_ok = supply_s & node_s;

  // Last oscillator cycle of a phase of length len
  function automatic logic phase_done(input logic [11:0] cnt, input logic [11:0] len, input logic tick);
    phase_done = tick && (cnt == len - 12'h001);
  endfunction : phase_done

  // ****************************************
  // Oscillator divider
  // ****************************************
  logic [5:0] div;
  logic [5:0] next_div;
  logic       osc_tick;

  assign osc_tick = (o_state != SSS_RESET) && (div == OSC_DIV - 6'h01);

  always_comb begin
    if (o_state == SSS_RESET || !release_ok) begin
      next_div = 6'h00;
    end else if (osc_tick) begin
      next_div = 6'h00;
    end else begin
      next_div = div + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div <= 6'h00;
    end else begin
      div <= next_div;
    end
  end

  // ****************************************
  // Sequencer state and phase counter
  // ****************************************
  sss_state_t  state;
  sss_state_t  next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (!release_ok) begin
      next_state = SSS_RESET;
      next_cnt   = 12'h000;
    end else begin
      case (state)
        SSS_RESET: begin
          next_state = SSS_SETTLE;
          next_cnt   = 12'h000;
        end
        SSS_SETTLE: begin
          if (phase_done(cnt, `SSS_SETTLE_CYC, osc_tick)) begin
            next_state = SSS_DISCH;
            next_cnt   = 12'h000;
          end else if (osc_tick) begin
            next_cnt = cnt + 12'h001;
          end
        end
        SSS_DISCH: begin
          if (phase_done(cnt, `SSS_DISCH_CYC, osc_tick)) begin
            next_state = SSS_RAMP;
            next_cnt   = `SSS_RAMP_CYC;
          end else if (osc_tick) begin
            next_cnt = cnt + 12'h001;
          end
        end
        SSS_RAMP: begin
          if (osc_tick) begin
            next_cnt = cnt - 12'h001;
            if (cnt == 12'h001) begin
              next_state = SSS_RUN;
            end
          end
        end
        SSS_RUN: begin
          next_cnt = 12'h000;
        end
        default: begin
          next_state = SSS_RESET;
          next_cnt   = 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= SSS_RESET;
      cnt   <= 12'h000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  sss_gate_t   next_gate;
  logic        next_force;
  logic [11:0] next_offset;
  logic        next_osc_en;

  always_comb begin
    next_gate.high_side_gate = 1'b0;
    next_gate.low_side_gate  = 1'b0;
    if (next_state == SSS_RUN) begin
      next_gate.high_side_gate = pwm_s;
      next_gate.low_side_gate  = ~pwm_s;
    end
    next_force  = (next_state == SSS_DISCH);
    case (next_state)
      SSS_RAMP: next_offset = next_cnt;
      SSS_RUN:  next_offset = `SSS_OFFSET_ZERO;
      default:  next_offset = `SSS_OFFSET_FULL;
    endcase
    next_osc_en = (next_state != SSS_RESET);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_gate        <= '0;
      o_sink_enable <= 1'b1;
      o_node_force  <= 1'b0;
      o_offset      <= `SSS_OFFSET_FULL;
      o_osc_enable  <= 1'b0;
      o_state       <= SSS_RESET;
    end else begin
      o_gate        <= next_gate;
      o_sink_enable <= 1'b1;
      o_node_force  <= next_force;
      o_offset      <= next_offset;
      o_osc_enable  <= next_osc_en;
      o_state       <= next_state;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_GATES_LOW: assert property (o_state != SSS_RUN |-> o_gate == 2'b00)
    else $error("Gates driven outside run state");

  AST_AUTO_START: assert property (o_state == SSS_RESET && release_ok |=> o_state == SSS_SETTLE)
    else $error("Sequence did not start after release");

  AST_SINK_ON: assert property ($past(i_rst) == 1'b0 |-> o_sink_enable)
    else $error("Shutdown node sink released");

  AST_SETTLE_END: assert property ($rose(o_node_force) |-> $past(o_state) == SSS_SETTLE
                                   && $past(cnt) == 12'h3FF && $past(osc_tick))
    else $error("Settling period length wrong");

  AST_DISCH_END: assert property (o_state == SSS_RAMP && $past(o_state) == SSS_DISCH
                                  |-> $past(cnt) == 12'h017 && o_offset == 12'h800)
    else $error("Discharge interval length wrong");

  AST_RAMP_STEP: assert property (o_state == SSS_RAMP && $past(o_state) == SSS_RAMP && $past(osc_tick)
                                  |-> o_offset == $past(o_offset) - 12'h001)
    else $error("Offset ramp step wrong");

  AST_DROP_RESET: assert property (!release_ok |=> o_state == SSS_RESET && !o_osc_enable)
    else $error("Release loss did not reset sequencer");

  AST_OSC_STOP: assert property (o_state == SSS_RESET |-> div == 6'h00 && !osc_tick ##1 cnt == 12'h000)
    else $error("Oscillator running in reset");

  AST_RUN_FOLLOW: assert property (o_state == SSS_RUN && $past(o_state) == SSS_RUN
                                   |-> o_gate.high_side_gate == $past(pwm_s)
                                   && o_gate.low_side_gate != o_gate.high_side_gate
                                   && o_offset == 12'h000)
    else $error("Gates not following comparator in run");

  COV_REACH_RUN: cover property (o_state == SSS_RAMP ##1 o_state == SSS_RUN);
  COV_DROP_RUN:  cover property (o_state == SSS_RUN ##1 o_state == SSS_RESET);
  COV_DROP_RAMP: cover property (o_state == SSS_RAMP ##1 o_state == SSS_RESET);

endmodule : sss_sequencer

// ---- sss_node_model.sv ----
// Model of the resistor source on the shutdown node
`timescale 1ns/10ps
module sss_node_model (
  input  wire logic i_sys_clk,
  input  wire logic i_pull_on,
  input  wire logic i_sink_enable,
  output logic      o_node_high
);
  logic float_q = 1'b0;
  // A node with neither source nor sink floats, seen as a changing level
  always @(posedge i_sys_clk) float_q <= ~float_q;
  // Resistor outweighs the sink current; without it the sink holds the node low
  assign o_node_high = i_pull_on | (~i_sink_enable & float_q);
endmodule : sss_node_model

// ---- soft_start_sequencer_tb.sv ----
// Self-checking testbench of the soft-start sequencer
`timescale 1ns/10ps
module soft_start_sequencer_tb;
  import sss_pkg::*;
  typedef struct {
    sss_state_t st;
    int         clocks;
    logic       force_on;
    int         steps;
  } sss_row_t;
  logic       i_sys_clk, i_rst, supply, pull, pwm, sink, force_on, osc;
  logic       node_high;
  sss_gate_t  gate;
  logic [11:0] offset;
  sss_state_t state;
  int         mismatches, num_checks, clk_n, step_n;
  sss_row_t   rows [3];
  sss_node_model node (.i_sys_clk(i_sys_clk), .i_pull_on(pull), .i_sink_enable(sink), .o_node_high(node_high));
  sss_sequencer #(.OSC_DIV(6'h02)) uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sense({supply, node_high, pwm}), .o_gate(gate),
    .o_sink_enable(sink), .o_node_force(force_on), .o_offset(offset), .o_osc_enable(osc), .o_state(state));
  // ****************************************
  // Clock, checks and closing
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : step
  task automatic idle(input logic [11:0] st, input logic [1:0] g);
    check("state", state, st);
    check("gate", gate, g);
    check("osc", osc, 1'b0);
    check("offset", offset, 12'h800);
    check("force", force_on, 1'b0);
  endtask : idle
  // Counts clocks spent in one state and changes of the offset code
  task automatic stay(input sss_state_t st);
    logic [11:0] last;
    clk_n = 0;
    step_n = 0;
    last = offset;
    while (state === st && clk_n < 9000) begin
      step(1);
      clk_n++;
      if (offset !== last) step_n++;
      last = offset;
    end
  endtask : stay
  initial begin
    #3_000_000;
    mismatches++;
    report_and_stop();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows = '{'{SSS_SETTLE, 2048, 1'b0, 0}, '{SSS_DISCH, 48, 1'b1, 0}, '{SSS_RAMP, 4096, 1'b0, 2048}};
    i_rst = 1'b1;
    supply = 1'b0;
    pull = 1'b0;
    pwm = 1'b0;
    mismatches = 0;
    num_checks = 0;
    step(15);
    @(posedge i_sys_clk) i_rst <= 1'b0;
    supply <= 1'b1;
    step(20);
    idle(SSS_RESET, 2'b00);
    check("sink", sink, 1'b1);
    @(posedge i_sys_clk) pull <= 1'b1;
    step(3);
    check("settle", state, SSS_SETTLE);
    foreach (rows[i]) begin
      check("phase", state, rows[i].st);
      check("force", force_on, rows[i].force_on);
      check("entry_offset", offset, 12'h800);
      check("osc", osc, 1'b1);
      check("gate", gate, 2'b00);
      stay(rows[i].st);
      check("clocks", clk_n, rows[i].clocks);
      check("steps", step_n, rows[i].steps);
    end
    check("run", state, SSS_RUN);
    check("run_offset", offset, 12'h000);
    @(posedge i_sys_clk) pwm <= 1'b1;
    step(4);
    check("gate_hi", gate, 2'b10);
    @(posedge i_sys_clk) pwm <= 1'b0;
    step(4);
    check("gate_lo", gate, 2'b01);
    @(posedge i_sys_clk) pwm <= 1'b1;
    pull <= 1'b0;
    step(4);
    idle(SSS_RESET, 2'b00);
    @(posedge i_sys_clk) pull <= 1'b1;
    step(40);
    check("rearm", state, SSS_SETTLE);
    @(posedge i_sys_clk) supply <= 1'b0;
    step(4);
    idle(SSS_RESET, 2'b00);
    @(posedge i_sys_clk) supply <= 1'b1;
    step(3);
    check("restart", state, SSS_SETTLE);
    @(posedge i_sys_clk) i_rst <= 1'b1;
    step(3);
    idle(SSS_RESET, 2'b00);
    // Release after a reset during settling: synchronisers refill before the sequence restarts
    @(posedge i_sys_clk) i_rst <= 1'b0;
    step(2);
    check("reset_hold", state, SSS_RESET);
    step(1);
    check("reset_restart", state, SSS_SETTLE);
    report_and_stop();
  end
endmodule : soft_start_sequencer_tb
